//--- core/rvt_pkg.sv
// Shared constants and types of the raster video timing engine.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package rvt_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 x index)
	// ----------------------------------------
	localparam int IDX_W = 10;
	localparam logic [9:0] IDX_BOOT = 10'h000;
	localparam logic [9:0] IDX_TIMING_FIRST = 10'h021;
	localparam logic [9:0] IDX_TIMING_LAST = 10'h02e;
	localparam logic [9:0] IDX_CTRL_A = 10'h060;
	localparam logic [9:0] IDX_STATUS = 10'h061;
	localparam logic [9:0] IDX_CTRL_B = 10'h070;

	// ----------------------------------------
	// Timing parameter slots, in index order
	// ----------------------------------------
	localparam int NUM_TP = 14;
	localparam logic [3:0] TP_HALFSYNC = 4'h0;
	localparam logic [3:0] TP_BACKPORCH = 4'h1;
	localparam logic [3:0] TP_DISPLAY = 4'h2;
	localparam logic [3:0] TP_SHORTDISP = 4'h3;
	localparam logic [3:0] TP_BROADPULSE = 4'h4;
	localparam logic [3:0] TP_VSYNC = 4'h5;
	localparam logic [3:0] TP_PRE_EQ = 4'h6;
	localparam logic [3:0] TP_POST_EQ = 4'h7;
	localparam logic [3:0] TP_VERTICAL_BLANK_COUNT = 4'h8;
	localparam logic [3:0] TP_VERTICAL_DISPLAY_COUNT = 4'h9;
	localparam logic [3:0] TP_LINETIME = 4'ha;
	localparam logic [3:0] TP_LINESTART = 4'hb;
	localparam logic [3:0] TP_MEMINIT = 4'hc;
	localparam logic [3:0] TP_DMA_LEAD = 4'hd;

	// ----------------------------------------
	// Control, boot and status fields
	// ----------------------------------------
	localparam int CTRL_W = 24;
	localparam logic [23:0] CTRL_RESET = 24'h000000;
	localparam int CB_ENABLE = 0;
	localparam int CB_INTERLACE = 1;
	localparam int CB_PAL = 2;
	localparam int CB_SLAVE = 3;
	localparam int CB_PLAIN_FLYBACK = 4;
	localparam int CB_SEPARATE_SYNC = 5;
	localparam int CB_FORCE_BLANK = 10;
	localparam int CB_DMA_OFF = 14;
	localparam int CB_INTERLEAVE = 18;
	localparam int BOOT_W = 7;
	localparam logic [6:0] BOOT_RESET = 7'h00;
	localparam int BT_PLL_LSB = 0;
	localparam int BT_CLK_SRC = 5;
	localparam int BT_ALIGN64 = 6;
	localparam int ST_RUNNING = 0;
	localparam int ST_FLYBACK = 1;
	localparam int ST_FIELD = 2;
	localparam int ST_FRAME_LSB = 3;
	localparam logic HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic interleave;
		logic dma_off;
		logic force_blank;
		logic separate_sync;
		logic plain_flyback;
		logic slave;
		logic pal;
		logic interlace;
		logic enable;
	} rvt_ctrl_s;

	typedef struct packed {
		logic align64;
		logic clk_src;
		logic [4:0] pll_mult;
	} rvt_boot_s;

	typedef enum logic [2:0] {
		FR_PRE = 3'b000,
		FR_VSYNC = 3'b001,
		FR_POST = 3'b011,
		FR_VERTICAL_BLANK_COUNT = 3'b010,
		FR_DISP = 3'b110
	} rvt_frame_e;

	typedef enum logic [2:0] {
		SEG_SYNC_A = 3'b000,
		SEG_SYNC_B = 3'b001,
		SEG_PORCH = 3'b011,
		SEG_ACTIVE = 3'b010,
		SEG_FRONT = 3'b110
	} rvt_seg_e;

	function automatic rvt_ctrl_s rvt_decode_ctrl(input logic [23:0] c);
		rvt_ctrl_s r;
		r.enable = c[CB_ENABLE];
		r.interlace = c[CB_INTERLACE];
		r.pal = c[CB_PAL];
		r.slave = c[CB_SLAVE];
		r.plain_flyback = c[CB_PLAIN_FLYBACK];
		r.separate_sync = c[CB_SEPARATE_SYNC];
		r.force_blank = c[CB_FORCE_BLANK];
		r.dma_off = c[CB_DMA_OFF];
		r.interleave = c[CB_INTERLEAVE];
		return r;
	endfunction

endpackage

//--- core/rvt_seg_timer.sv
// Down-counting segment timer of the raster timing engine.
// Assumes the caller reloads it on the cycle in which done is seen.
`timescale 1ns/100ps
`default_nettype none
module rvt_seg_timer #(
	parameter int W = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic [W-1:0] count,
	output logic done
);

	logic [W-1:0] next_count;

	// A loaded value of N gives a segment of exactly N cycles
	always_comb begin
		next_count = count;
		if (load) begin
			next_count = load_val;
		end else if (count != '0) begin
			next_count = count - {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign done = (count == {{(W-1){1'b0}}, 1'b1});

endmodule
`default_nettype wire

//--- core/rvt_video_timing_engine.sv
// Raster video timing engine with its AHB-Lite register slave.
// Assumes one clock at the serial pixel-word rate; sync pins are split into in/out/enable.
//
// Summary of operation
// - Drive sync, blank, DMA request, transfer, shift gates.
// - Flyback flag in frame flyback; blank all flyback.
// - Interlace and studio standard chosen by control bits.
// - Master drives sync pins; slave locks to them.
// - Horizontal timing counted in four-pixel screen units.
// - Frame counts in half lines, line in units.
// - Only display segment visible; rest of line blanked.
// - No front porch count; line ends at linetime.
// - Line sync is two back-to-back half-sync periods.
// - Advance segment when its count elapses; update outputs.
// - Vertical display in half lines, one field interlaced.
// - Four flyback counts in half lines sum blanking.
// - Vsync low is broad pulse; equalisation low half-sync.
// - Pre-eq, vsync and post-eq lines are half length, shortened sequences.
// - Setting enable starts at beginning of frame sync.
// - Control bits: enable, interlace, standard, slave.
// - Line counters advance once per serial clock.
// - Boot word holds multiplier, clock source, alignment.
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rvt_video_timing_engine #(
	parameter int TW = 12
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic vsync_n_i,
	output logic vsync_n_o,
	output logic vsync_n_oe,
	input wire logic csync_n_i,
	output logic csync_n_o,
	output logic csync_n_oe,
	output logic composite_blank,
	output logic frame_flyback_flag,
	output logic dma_bus_request,
	output logic [1:0] vram_row_transfer_strobes,
	output logic [1:0] pixel_shift_clocks,
	output logic field_odd,
	output rvt_pkg::rvt_boot_s boot_config
);

	// ----------------------------------------
	// Register file and bus slave
	// ----------------------------------------
	logic [TW-1:0] tparam [rvt_pkg::NUM_TP];
	logic [TW-1:0] next_tparam [rvt_pkg::NUM_TP];
	logic [23:0] ctrl_a, next_ctrl_a;
	logic [6:0] boot, next_boot;
	logic dp_write, next_dp_write;
	logic [9:0] dp_idx, next_dp_idx;
	logic [31:0] next_hrdata;
	logic [7:0] status;
	rvt_pkg::rvt_ctrl_s ctrl;
	logic ap_valid;
	logic [9:0] ap_idx;

	assign ctrl = rvt_pkg::rvt_decode_ctrl(ctrl_a);
	assign ap_valid = hsel && hready && htrans[1];
	assign ap_idx = haddr[11:2];

	function automatic logic is_timing(input logic [9:0] idx);
		return idx >= rvt_pkg::IDX_TIMING_FIRST && idx <= rvt_pkg::IDX_TIMING_LAST;
	endfunction

	always_comb begin
		logic [9:0] slot;
		slot = '0;
		next_tparam = tparam;
		next_ctrl_a = ctrl_a;
		next_boot = boot;
		next_dp_write = ap_valid && hwrite;
		next_dp_idx = ap_valid ? ap_idx : dp_idx;
		next_hrdata = '0;
		// Hsize is ignored: only whole-word transfers are expected
		if (dp_write) begin
			slot = dp_idx - rvt_pkg::IDX_TIMING_FIRST;
			if (dp_idx == rvt_pkg::IDX_CTRL_A) begin
				next_ctrl_a = hwdata[23:0];
			end else if (dp_idx == rvt_pkg::IDX_BOOT) begin
				next_boot = hwdata[6:0];
			end else if (is_timing(dp_idx) && !ctrl.enable) begin
				next_tparam[slot[3:0]] = hwdata[TW-1:0];
			end
		end
		if (ap_valid && !hwrite) begin
			slot = ap_idx - rvt_pkg::IDX_TIMING_FIRST;
			if (ap_idx == rvt_pkg::IDX_CTRL_A) begin
				next_hrdata = {8'h00, ctrl_a};
			end else if (ap_idx == rvt_pkg::IDX_BOOT) begin
				next_hrdata = {25'h0000000, boot};
			end else if (ap_idx == rvt_pkg::IDX_STATUS) begin
				next_hrdata = {24'h000000, status};
			end else if (is_timing(ap_idx) && !ctrl.enable) begin
				next_hrdata = {{(32-TW){1'b0}}, tparam[slot[3:0]]};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < rvt_pkg::NUM_TP; i++) begin
				tparam[i] <= '0;
			end
			ctrl_a <= rvt_pkg::CTRL_RESET;
			boot <= rvt_pkg::BOOT_RESET;
			dp_write <= 1'b0;
			dp_idx <= '0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= rvt_pkg::HRESP_OKAY;
		end else begin
			tparam <= next_tparam;
			ctrl_a <= next_ctrl_a;
			boot <= next_boot;
			dp_write <= next_dp_write;
			dp_idx <= next_dp_idx;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= rvt_pkg::HRESP_OKAY;
		end
	end

	// ----------------------------------------
	// Raster state machine
	// ----------------------------------------
	rvt_pkg::rvt_frame_e frame, next_frame;
	rvt_pkg::rvt_seg_e seg, next_seg;
	logic [TW-1:0] hpos, next_hpos, vcount, next_vcount, line_len, vlimit, tmr_val, tmr_cnt;
	logic [TW:0] vsum;
	logic field, next_field, vs_prev, hs_prev, tmr_load, tmr_done;
	logic line_full, line_end, ext_v_fall, ext_h_fall;

	rvt_seg_timer #(.W(TW)) i_rvt_seg_timer (
		.clk(hclk),
		.rst_n(hresetn),
		.load(tmr_load),
		.load_val(tmr_val),
		.count(tmr_cnt),
		.done(tmr_done)
	);

	function automatic rvt_pkg::rvt_frame_e frame_after(input rvt_pkg::rvt_frame_e f);
		case (f)
			rvt_pkg::FR_PRE: return rvt_pkg::FR_VSYNC;
			rvt_pkg::FR_VSYNC: return rvt_pkg::FR_POST;
			rvt_pkg::FR_POST: return rvt_pkg::FR_VERTICAL_BLANK_COUNT;
			rvt_pkg::FR_VERTICAL_BLANK_COUNT: return rvt_pkg::FR_DISP;
			default: return rvt_pkg::FR_PRE;
		endcase
	endfunction

	always_comb begin
		case (frame)
			rvt_pkg::FR_PRE: vlimit = tparam[rvt_pkg::TP_PRE_EQ];
			rvt_pkg::FR_VSYNC: vlimit = tparam[rvt_pkg::TP_VSYNC];
			rvt_pkg::FR_POST: vlimit = tparam[rvt_pkg::TP_POST_EQ];
			rvt_pkg::FR_VERTICAL_BLANK_COUNT: vlimit = tparam[rvt_pkg::TP_VERTICAL_BLANK_COUNT];
			default: vlimit = tparam[rvt_pkg::TP_VERTICAL_DISPLAY_COUNT];
		endcase
		// Full lines only in blank and display and only while two half lines remain
		line_full = (frame == rvt_pkg::FR_VERTICAL_BLANK_COUNT || frame == rvt_pkg::FR_DISP)
			&& (vlimit - vcount) >= {{(TW-2){1'b0}}, 2'b10};
		line_len = line_full ? tparam[rvt_pkg::TP_LINETIME]
			: {1'b0, tparam[rvt_pkg::TP_LINETIME][TW-1:1]};
		line_end = hpos >= line_len - {{(TW-1){1'b0}}, 1'b1};
		// Pins are taken as synchronous, so a one-flop history suffices for edges
		ext_v_fall = ctrl.slave && vs_prev && !vsync_n_i;
		ext_h_fall = ctrl.slave && hs_prev && !csync_n_i;
		vsum = {1'b0, vcount} + (line_full ? {{(TW-1){1'b0}}, 2'b10} : {{TW{1'b0}}, 1'b1});
		next_frame = frame;
		next_seg = seg;
		next_hpos = hpos + {{(TW-1){1'b0}}, 1'b1};
		next_vcount = vcount;
		next_field = field;
		tmr_load = 1'b0;
		tmr_val = tparam[rvt_pkg::TP_HALFSYNC];
		if (!ctrl.enable || ext_v_fall) begin
			next_frame = rvt_pkg::FR_PRE;
			next_seg = rvt_pkg::SEG_SYNC_A;
			next_hpos = '0;
			next_vcount = '0;
			next_field = ctrl.enable ? field : ctrl.pal;
			tmr_load = 1'b1;
		end else if (line_end || ext_h_fall) begin
			if (vsum >= {1'b0, vlimit}) begin
				next_frame = frame_after(frame);
				next_vcount = '0;
				if (frame == rvt_pkg::FR_DISP && ctrl.interlace) begin
					next_field = !field;
				end
			end else begin
				next_vcount = vsum[TW-1:0];
			end
			next_hpos = '0;
			next_seg = rvt_pkg::SEG_SYNC_A;
			tmr_load = 1'b1;
			if (next_frame == rvt_pkg::FR_VSYNC) begin
				tmr_val = tparam[rvt_pkg::TP_BROADPULSE];
			end
		end else if (tmr_done) begin
			tmr_load = 1'b1;
			case (seg)
				rvt_pkg::SEG_SYNC_A: begin
					if (frame == rvt_pkg::FR_VSYNC) begin
						next_seg = rvt_pkg::SEG_FRONT;
						tmr_load = 1'b0;
					end else begin
						next_seg = rvt_pkg::SEG_SYNC_B;
					end
				end
				rvt_pkg::SEG_SYNC_B: begin
					next_seg = rvt_pkg::SEG_PORCH;
					tmr_val = tparam[rvt_pkg::TP_BACKPORCH];
				end
				rvt_pkg::SEG_PORCH: begin
					next_seg = rvt_pkg::SEG_ACTIVE;
					tmr_val = line_full ? tparam[rvt_pkg::TP_DISPLAY] : tparam[rvt_pkg::TP_SHORTDISP];
				end
				default: begin
					next_seg = rvt_pkg::SEG_FRONT;
					tmr_load = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame <= rvt_pkg::FR_PRE;
			seg <= rvt_pkg::SEG_SYNC_A;
			hpos <= '0;
			vcount <= '0;
			field <= 1'b0;
			vs_prev <= 1'b1;
			hs_prev <= 1'b1;
		end else begin
			frame <= next_frame;
			seg <= next_seg;
			hpos <= next_hpos;
			vcount <= next_vcount;
			field <= next_field;
			vs_prev <= vsync_n_i;
			hs_prev <= csync_n_i;
		end
	end

	// ----------------------------------------
	// Sync, blank, DMA and shift outputs
	// ----------------------------------------
	logic hs_low, vs_low, cs_low, visible, dma_window;
	logic next_blank, next_flyback, next_req;
	logic [1:0] next_xfer, next_shift;

	always_comb begin
		hs_low = ctrl.enable && (seg == rvt_pkg::SEG_SYNC_A
			|| (seg == rvt_pkg::SEG_SYNC_B && line_full));
		vs_low = ctrl.enable && frame == rvt_pkg::FR_VSYNC;
		if (ctrl.separate_sync) begin
			cs_low = hs_low && !vs_low;
		end else if (ctrl.plain_flyback) begin
			cs_low = hs_low || vs_low;
		end else begin
			cs_low = hs_low; // Tesselated composite
		end
		visible = ctrl.enable && frame == rvt_pkg::FR_DISP && line_full
			&& seg == rvt_pkg::SEG_ACTIVE;
		next_blank = !visible || ctrl.force_blank;
		next_flyback = ctrl.enable && frame != rvt_pkg::FR_DISP;
		next_shift = {visible && ctrl.interleave, visible};
		// The request leads the display by the lead time; the strobe marks its end
		dma_window = ctrl.enable && !ctrl.dma_off && frame == rvt_pkg::FR_DISP
			&& line_full && seg == rvt_pkg::SEG_PORCH;
		next_req = dma_bus_request;
		next_xfer = 2'b00;
		if (dma_window && dma_bus_request && tmr_cnt == {{(TW-1){1'b0}}, 1'b1}) begin
			next_xfer = {ctrl.interleave, 1'b1};
			next_req = 1'b0;
		end else if (dma_window && tmr_cnt == tparam[rvt_pkg::TP_DMA_LEAD]) begin
			next_req = 1'b1;
		end else if (!dma_window) begin
			next_req = 1'b0;
		end
		status = {2'b00, frame, field, next_flyback, ctrl.enable};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			composite_blank <= 1'b1;
			frame_flyback_flag <= 1'b0;
			dma_bus_request <= 1'b0;
			vram_row_transfer_strobes <= 2'b00;
			pixel_shift_clocks <= 2'b00;
			vsync_n_o <= 1'b1;
			csync_n_o <= 1'b1;
			vsync_n_oe <= 1'b1;
			csync_n_oe <= 1'b1;
			field_odd <= 1'b0;
			boot_config <= '0;
		end else begin
			composite_blank <= next_blank;
			frame_flyback_flag <= next_flyback;
			dma_bus_request <= next_req;
			vram_row_transfer_strobes <= next_xfer;
			pixel_shift_clocks <= next_shift;
			vsync_n_o <= !vs_low;
			csync_n_o <= !cs_low;
			vsync_n_oe <= !ctrl.slave;
			csync_n_oe <= !ctrl.slave;
			field_odd <= field;
			boot_config <= boot;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_idle_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctrl.enable |=> composite_blank && !dma_bus_request && pixel_shift_clocks == 2'b00)
		else $error("Disabled engine not quiet");
	a_flyback_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		(ctrl.enable && frame != rvt_pkg::FR_DISP) |=> frame_flyback_flag && composite_blank)
		else $error("Flyback flag or blank missing");
	a_blank_outside: assert property (@(posedge hclk) disable iff (!hresetn)
		(seg != rvt_pkg::SEG_ACTIVE) |=> composite_blank)
		else $error("Visible outside display segment");
	a_line_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		(ctrl.enable && hpos == line_len - {{(TW-1){1'b0}}, 1'b1} && !ext_v_fall)
		|=> hpos == '0 && seg == rvt_pkg::SEG_SYNC_A)
		else $error("Line did not end at linetime");
	a_sync_pair: assert property (@(posedge hclk) disable iff (!hresetn)
		(ctrl.enable && seg == rvt_pkg::SEG_SYNC_A && line_full && tmr_done && !line_end && !ext_v_fall
		&& !ext_h_fall) |=> seg == rvt_pkg::SEG_SYNC_B ##1 !csync_n_o || ctrl.separate_sync)
		else $error("Second half sync missing");
	a_half_line: assert property (@(posedge hclk) disable iff (!hresetn)
		(frame != rvt_pkg::FR_DISP && frame != rvt_pkg::FR_VERTICAL_BLANK_COUNT)
		|-> line_len == {1'b0, tparam[rvt_pkg::TP_LINETIME][TW-1:1]})
		else $error("Flyback line not half length");
	a_start_frame: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(ctrl.enable) |-> frame == rvt_pkg::FR_PRE && hpos == '0 && seg == rvt_pkg::SEG_SYNC_A)
		else $error("Engine did not start at frame sync");
	a_pin_drive: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl.slave |=> !vsync_n_oe && !csync_n_oe)
		else $error("Slave drives sync pins");
	a_vsync_pin: assert property (@(posedge hclk) disable iff (!hresetn)
		(vs_low && !ctrl.slave) |=> !vsync_n_o && vsync_n_oe)
		else $error("Vertical sync not driven low");
	a_segment_step: assert property (@(posedge hclk) disable iff (!hresetn)
		(ctrl.enable && seg == rvt_pkg::SEG_PORCH && tmr_done && !line_end && !ext_v_fall && !ext_h_fall)
		|=> seg == rvt_pkg::SEG_ACTIVE)
		else $error("Segment did not advance");
	c_enable: cover property (@(posedge hclk) disable iff (!hresetn) $rose(ctrl.enable));
	c_display: cover property (@(posedge hclk) disable iff (!hresetn) !composite_blank);
	c_transfer: cover property (@(posedge hclk) disable iff (!hresetn) vram_row_transfer_strobes[0]);
	c_slave_lock: cover property (@(posedge hclk) disable iff (!hresetn) ext_v_fall);

endmodule
`default_nettype wire

//--- sim/rvt_sync_partner.sv
// Far-side sync partner: pull-ups on both sync lines and an external sync source.
// Assumes the engine's sync pins come split into out and enable; the bench asks for vsync pulses.
`timescale 1ns/100ps
`default_nettype none
module rvt_sync_partner (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic vsync_n_o,
	input wire logic vsync_n_oe,
	input wire logic csync_n_o,
	input wire logic csync_n_oe,
	input wire logic vsync_req,
	output logic vsync_n,
	output logic csync_n
);
	// ----------------------------------------
	// External source, one line per 60 units
	// ----------------------------------------
	logic [1:0] vlow;
	logic [5:0] hcnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vlow <= 2'h0;
			hcnt <= 6'h00;
		end else begin
			vlow <= vsync_req ? 2'h2 : (vlow != 2'h0 ? vlow - 2'h1 : 2'h0);
			hcnt <= (hcnt == 6'h3b) ? 6'h00 : hcnt + 6'h01;
		end
	end
	// Released lines follow the external source, high between its pulses
	assign vsync_n = vsync_n_oe ? vsync_n_o : (vlow == 2'h0);
	assign csync_n = csync_n_oe ? csync_n_o : (hcnt > 6'h03);
endmodule
`default_nettype wire

//--- sim/rvt_video_timing_engine_tb.sv
// Self-checking bench of the raster video timing engine.
// Assumes the engine is the sole AHB-Lite slave; the partner resolves the sync pins.
`timescale 1ns/100ps
`default_nettype none
module rvt_video_timing_engine_tb;
	logic hclk, hresetn, hsel, hwrite, vreq, hreadyout, hresp, vs_o, vs_oe, cs_o, cs_oe, vs_n, cs_n;
	logic blank, flag, dma, fodd, dma_q, f0;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, strb, shft;
	logic [2:0] hsize;
	rvt_pkg::rvt_boot_s boot;
	int errors, cmp_count, n, s0, d0, nstrb, ndma;
	// Halfsync, porch, display, short, broad, vsync, pre, post, vertical_blank_count, vdisp, linetime, start, init, lead
	logic [31:0] tpv [0:13] = '{32'h2, 32'h12, 32'h14, 32'h6, 32'h1a, 32'h3, 32'h3, 32'h3, 32'h4, 32'h8,
		32'h3c, 32'ha, 32'ha, 32'h4};

	rvt_video_timing_engine #(.TW(12)) i_rvt_video_timing_engine (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .vsync_n_i(vs_n),
		.vsync_n_o(vs_o), .vsync_n_oe(vs_oe), .csync_n_i(cs_n), .csync_n_o(cs_o), .csync_n_oe(cs_oe),
		.composite_blank(blank), .frame_flyback_flag(flag), .dma_bus_request(dma),
		.vram_row_transfer_strobes(strb), .pixel_shift_clocks(shft), .field_odd(fodd), .boot_config(boot));
	rvt_sync_partner i_rvt_sync_partner (.hclk(hclk), .hresetn(hresetn), .vsync_n_o(vs_o),
		.vsync_n_oe(vs_oe), .csync_n_o(cs_o), .csync_n_oe(cs_oe), .vsync_req(vreq), .vsync_n(vs_n),
		.csync_n(cs_n));

	// ----------------------------------------
	// Clock, event counters, watchdog
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		dma_q <= dma;
		if (strb[0] === 1'b1) nstrb <= nstrb + 1;
		if (dma === 1'b1 && dma_q === 1'b0) ndma <= ndma + 1;
	end
	initial begin
		#(100 * 20000);
		errors++;
		test_done();
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Single word transfer; read data is taken at the edge ending the data phase
	// Only the watchdog ends a wait for hready
	task automatic bus(input logic [9:0] idx, input logic wr, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {20'h00000, idx, 2'b00};
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return cs_n;
			1: return blank;
			2: return flag;
			default: return vs_n;
		endcase
	endfunction
	// Waits for a line to reach level v, or counts while it holds v, sampled at rising edges
	task automatic run(input int k, input logic v, input logic hold, output int c);
		c = 0;
		while ((sig(k) === v) == hold && c < 1000) begin
			@(posedge hclk);
			c++;
		end
	endtask
	task automatic wait_for(input int k, input logic v);
		run(k, v, 1'b0, n);
		if (n == 1000) chk(32'h0, 32'h1);
	endtask
	task automatic run_len(input int k, input logic v, input int exp);
		run(k, v, 1'b1, n);
		chk(n, exp);
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, vreq, dma_q} = 4'h0;
		{haddr, hwdata} = 64'h0;
		htrans = 2'b00;
		hsize = 3'b010;
		{errors, cmp_count, nstrb, ndma} = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({hreadyout, hresp, blank, cs_n, flag, dma}, 6'b101100);
		bus(rvt_pkg::IDX_BOOT, 1'b1, 32'h45);
		// The boot word reaches its output one register stage after the write lands
		repeat (2) @(posedge hclk);
		chk(boot, 7'h45);
		bus(rvt_pkg::IDX_CTRL_A, 1'b1, 32'h0);
		for (int i = 0; i < 14; i++) bus(rvt_pkg::IDX_TIMING_FIRST + 10'(i), 1'b1, tpv[i]);
		for (int i = 0; i < 14; i++) begin
			bus(rvt_pkg::IDX_TIMING_FIRST + 10'(i), 1'b0, 32'h0);
			chk(rd, tpv[i]);
		end
		bus(10'h040, 1'b1, 32'hffffffff);
		bus(10'h040, 1'b0, 32'h0);
		chk(rd, 32'h0);
		bus(rvt_pkg::IDX_CTRL_A, 1'b1, 32'h1);
		wait_for(0, 1'b0);
		run_len(0, 1'b0, 2);
		bus(rvt_pkg::IDX_TIMING_FIRST, 1'b1, 32'h5);
		bus(rvt_pkg::IDX_TIMING_FIRST, 1'b0, 32'h0);
		chk(rd, 32'h0);
		bus(rvt_pkg::IDX_STATUS, 1'b0, 32'h0);
		chk(rd & 32'h1, 32'h1);
		wait_for(2, 1'b0);
		wait_for(2, 1'b1);
		s0 = nstrb;
		d0 = ndma;
		run_len(2, 1'b1, 390);
		run_len(2, 1'b0, 240);
		chk(nstrb - s0, 4);
		chk(ndma - d0, 4);
		wait_for(2, 1'b0);
		wait_for(1, 1'b0);
		chk(shft, 32'h1);
		run_len(1, 1'b0, 20);
		run_len(1, 1'b1, 40);
		wait_for(0, 1'b0);
		run_len(0, 1'b0, 4);
		wait_for(3, 1'b0);
		run_len(0, 1'b0, 26);
		wait_for(3, 1'b1);
		wait_for(3, 1'b0);
		run_len(3, 1'b0, 90);
		bus(rvt_pkg::IDX_CTRL_A, 1'b1, 32'h0);
		// Interlace wants an odd number of half lines in the vertical display count
		bus(rvt_pkg::IDX_TIMING_FIRST + 10'(rvt_pkg::TP_VERTICAL_DISPLAY_COUNT), 1'b1, 32'h9);
		bus(rvt_pkg::IDX_CTRL_A, 1'b1, 32'h7);
		for (int f = 0; f < 2; f++) begin
			wait_for(2, 1'b0);
			wait_for(2, 1'b1);
			repeat (5) @(posedge hclk);
			if (f == 0) f0 = fodd;
		end
		chk(fodd, 32'(!f0));
		bus(rvt_pkg::IDX_CTRL_A, 1'b1, 32'h0);
		repeat (2) @(posedge hclk);
		chk({blank, flag, dma, strb, shft}, 7'b1000000);
		bus(rvt_pkg::IDX_TIMING_FIRST, 1'b0, 32'h0);
		chk(rd, 32'h2);
		bus(rvt_pkg::IDX_CTRL_A, 1'b1, 32'hb);
		repeat (2) @(posedge hclk);
		chk({vs_oe, cs_oe}, 2'b00);
		wait_for(2, 1'b0);
		vreq <= 1'b1;
		@(posedge hclk);
		vreq <= 1'b0;
		wait_for(2, 1'b1);
		chk(n < 8, 1);
		test_done();
	end
endmodule
`default_nettype wire
